// ---- core/pll_clock_config_switch.v ----
// Clock prescaler, PLL rate model and oscillator switch controller.
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_config_switch_defines.vh"

module pll_clock_config_switch
#(
  parameter FAILSAFE_CLOCK_MONITOR_TIMEOUT = `FAILSAFE_CLOCK_MONITOR_TIMEOUT_CYC,
  parameter SETTLE_EDGES = `SETTLE_EDGES
)
(
  // Clock and reset.
  input  wire               sys_clk_in,
  input  wire               resetn_in,
  // Oscillator inputs.
  input  wire               primary_osc_in,
  input  wire               rc_osc_in,
  // Register port.
  input  wire [`ADDR_W-1:0] addr_in,
  input  wire [`DATA_W-1:0] wr_data_in,
  input  wire               wr_en_in,
  input  wire               rd_en_in,
  output reg  [`DATA_W-1:0] rd_data_out,
  // Clock results.
  output reg                fosc_tick_out,
  output reg                fcy_tick_out,
  output reg  [2:0]         cur_osc_out,
  output reg                pll_active_out,
  // Interrupt.
  output reg                irq_out
);

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_CHANGE = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  reg  [4:0]  pre_r;
  reg  [1:0]  post_r;
  reg  [8:0]  fbd_r;
  reg  [2:0]  new_osc_select_r;
  reg         cf_r;
  reg         swreq_r;
  reg  [1:0]  key_r;
  reg  [1:0]  stat_r;
  reg  [1:0]  en_r;
  reg  [2:0]  state_r;
  reg  [4:0]  settle_r;
  reg  [15:0] fail_cnt_r;
  reg  [10:0] acc_r;
  reg         fcy_ph_r;
  reg         pri_d_r;
  reg         rc_d_r;

  wire wr_ctrl = wr_en_in && (addr_in == `OFS_OSC_CTRL);
  wire unlocked = (key_r == 2'h2);
  wire ctrl_ok = wr_ctrl && unlocked;

  wire pri_edge = primary_osc_in & ~pri_d_r;
  wire rc_edge  = rc_osc_in & ~rc_d_r;

  // Source and path follow the current mode.
  wire src_edge = cur_osc_out[1] ? pri_edge : rc_edge;
  wire new_edge = new_osc_select_r[1] ? pri_edge : rc_edge;

  wire [5:0]  n1 = {1'b0, pre_r} + 6'd2;
  reg  [3:0]  n2;
  wire [9:0]  mult = {1'b0, fbd_r} + 10'd2;
  wire [9:0]  divr = {4'h0, n1} * {6'h00, n2};
  wire [10:0] sum = acc_r + (src_edge ? {1'b0, mult} : 11'h000);

  always @*
  begin
    case (post_r)
      2'h0:    n2 = 4'd2;
      2'h1:    n2 = 4'd4;
      default: n2 = 4'd8;
    endcase
  end

  // Moving between the two PLL modes is refused as a whole request.
  wire pll_hop = cur_osc_out[0] && new_osc_select_r[0] &&
                 (cur_osc_out[1] != new_osc_select_r[1]);
  wire fail_hit = cur_osc_out[1] &&
                  (fail_cnt_r >= FAILSAFE_CLOCK_MONITOR_TIMEOUT[15:0] - 16'd1);
  reg  done_ev;
  wire fail_ev = fail_hit && !cf_r;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key: 0x55 then 0xaa opens one control write.
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      key_r <= 2'h0;
    else if (wr_en_in && addr_in == `OFS_UNLOCK_KEY)
    begin
      if (wr_data_in == `KEY_FIRST)
        key_r <= 2'h1;
      else if (wr_data_in == `KEY_SECOND && key_r == 2'h1)
        key_r <= 2'h2;
      else
        key_r <= 2'h0;
    end
    else if (wr_en_in)
      key_r <= 2'h0;
  end

  // Divider and feedback registers are not guarded by the key.
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pre_r  <= `RST_PRE;
      post_r <= `RST_POST;
      fbd_r  <= `RST_FBD;
      en_r   <= 2'h0;
    end
    else if (wr_en_in)
    begin
      if (addr_in == `OFS_CLK_DIV)
      begin
        pre_r  <= wr_data_in[`PRE_HI:`PRE_LO];
        post_r <= wr_data_in[`POST_HI:`POST_LO];
      end
      if (addr_in == `OFS_PLL_FBD)
        fbd_r <= wr_data_in[`FBD_HI:`FBD_LO];
      if (addr_in == `OFS_IRQ_ENABLE)
        en_r <= wr_data_in[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch controller and fail-safe monitor share the source select.
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r     <= ST_IDLE;
      cur_osc_out <= `OSC_RC;
      new_osc_select_r      <= `OSC_RC;
      swreq_r     <= 1'b0;
      cf_r        <= 1'b0;
      settle_r    <= 5'h00;
      fail_cnt_r  <= 16'h0000;
      done_ev     <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      // A new selection mid-switch would dodge the PLL hop check.
      if (ctrl_ok && state_r == ST_IDLE)
        new_osc_select_r <= wr_data_in[`NEW_OSC_HI:`NEW_OSC_LO];
      if (!cur_osc_out[1] || pri_edge)
        fail_cnt_r <= 16'h0000;
      else
        fail_cnt_r <= fail_cnt_r + 16'h0001;
      // A failure set beats a clear in the same cycle.
      if (fail_hit)
        cf_r <= 1'b1;
      else if (ctrl_ok && !wr_data_in[`CLK_FAIL_BIT])
        cf_r <= 1'b0;
      if (fail_hit)
      begin
        // Fall back to the internal oscillator and drop any request.
        cur_osc_out <= `OSC_RC;
        swreq_r     <= 1'b0;
        state_r     <= ST_IDLE;
        fail_cnt_r  <= 16'h0000;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (ctrl_ok && wr_data_in[`SWITCH_REQ_BIT])
              swreq_r <= 1'b1;
            if (swreq_r)
            begin
              if (pll_hop || new_osc_select_r == cur_osc_out)
              begin
                swreq_r <= 1'b0;
                done_ev <= !pll_hop;
              end
              else
              begin
                settle_r <= 5'h00;
                state_r  <= ST_SETTLE;
              end
            end
          end
          ST_SETTLE:
          begin
            // The old source keeps clocking while the new one settles.
            if (new_edge)
            begin
              settle_r <= settle_r + 5'h01;
              if (settle_r == SETTLE_EDGES[4:0] - 5'h01)
                state_r <= ST_CHANGE;
            end
          end
          ST_CHANGE:
          begin
            // No tick is issued here, so the changeover cannot glitch.
            cur_osc_out <= new_osc_select_r;
            swreq_r     <= 1'b0;
            done_ev     <= 1'b1;
            state_r     <= ST_IDLE;
          end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate model: M edges owed per input edge, one tick per N1*N2 owed.
  // Accuracy holds while the output rate stays below the bus clock.
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pri_d_r        <= 1'b0;
      rc_d_r         <= 1'b0;
      acc_r          <= 11'h000;
      fosc_tick_out  <= 1'b0;
      fcy_tick_out   <= 1'b0;
      fcy_ph_r       <= 1'b0;
      pll_active_out <= 1'b0;
    end
    else
    begin
      pri_d_r        <= primary_osc_in;
      rc_d_r         <= rc_osc_in;
      pll_active_out <= cur_osc_out[0];
      if (state_r == ST_CHANGE || fail_hit)
      begin
        acc_r         <= 11'h000;
        fosc_tick_out <= 1'b0;
        fcy_tick_out  <= 1'b0;
      end
      else
      begin
        if (!cur_osc_out[0])
          fosc_tick_out <= src_edge;
        else if (sum >= {1'b0, divr})
        begin
          acc_r         <= sum - {1'b0, divr};
          fosc_tick_out <= 1'b1;
        end
        else
        begin
          acc_r         <= sum;
          fosc_tick_out <= 1'b0;
        end
        if (fosc_tick_out)
          fcy_ph_r <= ~fcy_ph_r;
        fcy_tick_out <= fosc_tick_out && fcy_ph_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: events set, clear register clears, set wins.
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      stat_r  <= 2'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_en_in && addr_in == `OFS_IRQ_CLEAR)
        stat_r <= (stat_r & ~wr_data_in[1:0]) |
                  {fail_ev, done_ev};
      else
        stat_r <= stat_r | {fail_ev, done_ev};
      irq_out <= |(stat_r & en_r);
    end
  end

  // Read data stand for exactly one cycle after the strobe.
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rd_data_out <= 16'h0000;
    else if (!rd_en_in)
      rd_data_out <= 16'h0000;
    else
    begin
      case (addr_in)
        `OFS_OSC_CTRL:
          rd_data_out <= {1'b0, cur_osc_out, 1'b0, new_osc_select_r, 4'h0,
                          cf_r, 2'h0, swreq_r};
        `OFS_CLK_DIV:    rd_data_out <= {8'h00, post_r, 1'b0, pre_r};
        `OFS_PLL_FBD:    rd_data_out <= {7'h00, fbd_r};
        `OFS_IRQ_STATUS: rd_data_out <= {14'h0000, stat_r};
        `OFS_IRQ_ENABLE: rd_data_out <= {14'h0000, en_r};
        default:         rd_data_out <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- core/pll_clock_config_switch_defines.vh ----
// Register map, field positions, reset values and timing counts.
// Behaviour
// - Input clock divided by prescale 2 through 33.
// - Prescale field zero selects divide by two.
// - Nine-bit feedback field sets VCO multiplier.
// - Feedback field value plus two is multiplier.
// - Two-bit postscale field at bits 7:6 divides.
// - Postscale field zero selects divide by two.
// - System clock is input times M over N1*N2.
// - Instruction rate is system clock halved.
// - PLL or direct path follows oscillator mode.
// - Monitor sets clock fail flag; software clears.
// - Switch request bit self-clears on completion.
// - Control bits 2 and 1 read as zero.
`ifndef PLL_CLOCK_CONFIG_SWITCH_DEFINES_VH
`define PLL_CLOCK_CONFIG_SWITCH_DEFINES_VH

`define ADDR_W            3
`define DATA_W            16
`define OFS_OSC_CTRL      3'h0
`define OFS_CLK_DIV       3'h1
`define OFS_PLL_FBD       3'h2
`define OFS_UNLOCK_KEY    3'h3
`define OFS_IRQ_STATUS    3'h4
`define OFS_IRQ_CLEAR     3'h5
`define OFS_IRQ_ENABLE    3'h6

`define CUR_OSC_HI        14
`define CUR_OSC_LO        12
`define NEW_OSC_HI        10
`define NEW_OSC_LO        8
`define CLK_FAIL_BIT      3
`define SWITCH_REQ_BIT    0
`define PRE_HI            4
`define PRE_LO            0
`define POST_HI           7
`define POST_LO           6
`define FBD_HI            8
`define FBD_LO            0

`define OSC_RC            3'h0
`define OSC_RC_PLL        3'h1
`define OSC_PRI           3'h2
`define OSC_PRI_PLL       3'h3

`define RST_PRE           5'h00
`define RST_POST          2'h0
`define RST_FBD           9'h030

`define KEY_FIRST         16'h0055
`define KEY_SECOND        16'h00aa

`define IRQ_SWITCH_DONE   0
`define IRQ_CLK_FAIL      1

`define CLK_PERIOD_NS     5
`define FAILSAFE_CLOCK_MONITOR_TIMEOUT_NS   2000
`define FAILSAFE_CLOCK_MONITOR_TIMEOUT_CYC  (`FAILSAFE_CLOCK_MONITOR_TIMEOUT_NS / `CLK_PERIOD_NS)
`define SETTLE_EDGES      16

`endif

// ---- testbench/osc_source_model.sv ----
// Behavioural primary and internal RC oscillator sources.
`timescale 1ns/1ps
`default_nettype none
module osc_source_model
(
  // Control from the bench.
  input  wire logic pri_stop_in,
  // Oscillator levels.
  output var  logic pri_osc_out,
  output var  logic rc_osc_out
);
  // Half periods are not multiples of the system clock, so edges drift
  // against it, yet each level outlasts one sample.
  initial pri_osc_out = 1'b0;
  initial rc_osc_out = 1'b0;
  // A dead crystal holds its level, which the monitor has to notice.
  always #7 if (!pri_stop_in) pri_osc_out = !pri_osc_out;
  always #12 rc_osc_out = !rc_osc_out;
endmodule
`default_nettype wire

// ---- testbench/pll_clock_config_switch_assertions.sv ----
// Port-level checks for the PLL clock switch block.
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_config_switch_defines.vh"
module pll_clock_config_switch_assertions
(
  // Inputs and results watched.
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  input wire logic        primary_osc_in,
  input wire logic        rc_osc_in,
  input wire logic [2:0]  addr_in,
  input wire logic        rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        fosc_tick_out,
  input wire logic        fcy_tick_out,
  input wire logic [2:0]  cur_osc_out,
  input wire logic        pll_active_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  AST_RSVD: assert property ($past(rd_en_in && addr_in == 3'h0)
    |-> rd_data_out[2:1] == 2'b00) else $error("reserved bits set");
  AST_PLL_FLAG: assert property (pll_active_out == $past(cur_osc_out[0]))
    else $error("pll flag wrong");
  AST_MODE: assert property (cur_osc_out <= `OSC_PRI_PLL)
    else $error("illegal mode");
  AST_NO_HOP: assert property (cur_osc_out[0] && $past(cur_osc_out[0])
    |-> $stable(cur_osc_out)) else $error("direct pll hop");
  AST_RC_TICK: assert property ($rose(rc_osc_in)
    && cur_osc_out == `OSC_RC |-> ##[1:5]
    (fosc_tick_out || cur_osc_out != `OSC_RC)) else $error("rc tick lost");
  AST_PRI_TICK: assert property ($rose(primary_osc_in)
    && cur_osc_out == `OSC_PRI |-> ##[1:5]
    (fosc_tick_out || cur_osc_out != `OSC_PRI)) else $error("pri tick lost");
  AST_FOSC_GAP: assert property (fosc_tick_out |=> !fosc_tick_out)
    else $error("fosc back to back");
  AST_FCY_GAP: assert property (fcy_tick_out |=> !fcy_tick_out [*2])
    else $error("fcy too fast");
endmodule
bind pll_clock_config_switch pll_clock_config_switch_assertions chk_inst (
  .sys_clk_in     (sys_clk_in),
  .resetn_in      (resetn_in),
  .primary_osc_in (primary_osc_in),
  .rc_osc_in      (rc_osc_in),
  .addr_in        (addr_in),
  .rd_en_in       (rd_en_in),
  .rd_data_out    (rd_data_out),
  .fosc_tick_out  (fosc_tick_out),
  .fcy_tick_out   (fcy_tick_out),
  .cur_osc_out    (cur_osc_out),
  .pll_active_out (pll_active_out)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the PLL clock switch block.
`timescale 1ns/1ps
`default_nettype none
`include "pll_clock_config_switch_defines.vh"
module testbench;
  logic        sys_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [2:0]  addr_in = 3'h0;
  logic [15:0] wr_data_in = 16'h0000;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic        pri_stop = 1'b0;
  logic        rd_seen = 1'b0;
  logic        primary_osc_in, rc_osc_in, fosc_tick_out, fcy_tick_out;
  logic        pll_active_out, irq_out, pri_q;
  logic [15:0] rd_data_out;
  logic [2:0]  cur_osc_out;
  logic [31:0] e, r, exp_q[$];
  // The sources run scaled, so only the ratios keep the rate limits.
  logic [31:0] rate[3] = '{32'h0040_0002,
                           32'h0001_0001, 32'h00c0_0006};
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed = 27430;
  int          n_pri, n_fosc, n_fcy;

  always #2.5 sys_clk_in = !sys_clk_in;
  pll_clock_config_switch #(.FAILSAFE_CLOCK_MONITOR_TIMEOUT(20), .SETTLE_EDGES(4))
    pll_clock_config_switch_inst (.*);
  osc_source_model osc_source_model_inst (.pri_stop_in(pri_stop),
    .pri_osc_out(primary_osc_in), .rc_osc_out(rc_osc_in));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    cy(1);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    cy(1);
    wr_en_in <= 1'b0;
  endtask
  // The note is queued before the strobe, so the watcher always finds it.
  task automatic rd(input logic [2:0] a, input logic [15:0] m, x);
    exp_q.push_back({m, x});
    cy(1);
    addr_in <= a;
    rd_en_in <= 1'b1;
    cy(1);
    rd_en_in <= 1'b0;
  endtask
  task automatic ctrl(input logic [15:0] d);
    wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
    wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
    wr(`OFS_OSC_CTRL, d);
  endtask
  task automatic wt(input logic [2:0] n);
    int i;
    for (i = 0; i < 300 && cur_osc_out !== n; i++)
      cy(1);
    chk(cur_osc_out === n, "mode not reached");
  endtask
  task automatic go(input logic [2:0] n);
    ctrl({5'h00, n, 8'h01});
    wt(n);
  endtask

  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    rd_seen <= rd_en_in;
    pri_q <= primary_osc_in;
    n_pri += (primary_osc_in && !pri_q);
    n_fosc += fosc_tick_out;
    n_fcy += fcy_tick_out;
    if (rd_seen === 1'b1)
    begin
      e = exp_q.pop_front();
      chk((rd_data_out & e[31:16]) === e[15:0], "read data");
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test;
    end
  end

  initial
  begin
    cy(3);
    resetn_in <= 1'b1;
    rd(`OFS_CLK_DIV, 16'hffff, 16'h0000);
    rd(`OFS_PLL_FBD, 16'hffff, 16'h0030);
    rd(`OFS_OSC_CTRL, 16'hffff, 16'h0000);
    rd(3'h7, 16'hffff, 16'h0000);
    $display("test reset done");
    wr(`OFS_CLK_DIV, 16'h00df);
    rd(`OFS_CLK_DIV, 16'hffff, 16'h00df);
    repeat (6)
    begin
      r = $random(seed);
      wr(`OFS_CLK_DIV, {8'h00, r[7:6], 1'b0, r[4:0]});
      wr(`OFS_PLL_FBD, {7'h00, r[24:16]});
      rd(`OFS_CLK_DIV, 16'hffff, {8'h00, r[7:6], 1'b0, r[4:0]});
      rd(`OFS_PLL_FBD, 16'hffff, {7'h00, r[24:16]});
    end
    $display("test divider done");
    wr(`OFS_OSC_CTRL, 16'h0201);
    wr(`OFS_UNLOCK_KEY, `KEY_FIRST);
    wr(`OFS_UNLOCK_KEY, `KEY_SECOND);
    wr(`OFS_IRQ_ENABLE, 16'h0003);
    wr(`OFS_OSC_CTRL, 16'h0201);
    rd(`OFS_OSC_CTRL, 16'hffff, 16'h0000);
    $display("test lock done");
    go(`OSC_PRI);
    cy(2);
    chk(irq_out === 1'b1, "no switch irq");
    rd(`OFS_OSC_CTRL, 16'hffff, 16'h2200);
    rd(`OFS_IRQ_STATUS, 16'hffff, 16'h0001);
    wr(`OFS_IRQ_ENABLE, 16'h0002);
    cy(2);
    chk(irq_out === 1'b0, "irq not masked");
    wr(`OFS_IRQ_CLEAR, 16'h0001);
    wr(`OFS_IRQ_ENABLE, 16'h0003);
    rd(`OFS_IRQ_STATUS, 16'hffff, 16'h0000);
    chk(irq_out === 1'b0, "irq not cleared");
    $display("test switch done");
    // Leftover random settings would overrun the tick model.
    wr(`OFS_CLK_DIV, rate[0][31:16]);
    wr(`OFS_PLL_FBD, rate[0][15:0]);
    go(`OSC_PRI_PLL);
    foreach (rate[k])
    begin
      wr(`OFS_CLK_DIV, rate[k][31:16]);
      wr(`OFS_PLL_FBD, rate[k][15:0]);
      n_pri = 0;
      n_fosc = 0;
      n_fcy = 0;
      cy(400);
      chk(n_fosc * 2 - n_pri inside {[-3:3]}, "pll rate");
      chk(n_fcy * 2 - n_fosc inside {[-2:2]}, "instruction rate");
    end
    chk(pll_active_out === 1'b1, "pll flag clear");
    ctrl({5'h00, `OSC_RC_PLL, 8'h01});
    cy(4);
    rd(`OFS_OSC_CTRL, 16'h7001, 16'h3000);
    go(`OSC_RC);
    cy(1);
    chk(pll_active_out === 1'b0, "pll flag set");
    go(`OSC_RC_PLL);
    go(`OSC_PRI);
    $display("test pll done");
    pri_stop <= 1'b1;
    wt(`OSC_RC);
    rd(`OFS_OSC_CTRL, 16'h7009, 16'h0008);
    rd(`OFS_IRQ_STATUS, 16'h0002, 16'h0002);
    chk(irq_out === 1'b1, "no fail irq");
    ctrl(16'h0000);
    rd(`OFS_OSC_CTRL, 16'h0008, 16'h0000);
    $display("test fail done");
    stop_test;
  end
endmodule
`default_nettype wire
